/* hw/acs_sequencer.sv */
/*
  Conversion and calibration sequencer with its serial port.
  Assumes clk is the 10 ns master clock, the serial clock and frame sync come
  from the host (or the serial clock is looped back from serial_clk_out in the
  generated-clock modes), and the mode and edge straps are static.
*/
// What this block does
// - start strobe falling begins conversion, raises busy
// - conversion lasts eighteen master clock periods
// - full self-calibration lasts 125013 periods
// - DAC plus full-scale calibration lasts 111114
// - offset calibration lasts 13899 periods
// - busy rises promptly after start or calibrate
// - device drives serial clock in modes 4-5
// - data output driven only while sync low
// - shared input pin turns around on rising edges
// - sample on rising, present on falling edge
// - edge-select low swaps both serial edges
// - command word also starts a conversion
`timescale 1ns/10ps
module acs_sequencer #(
  parameter logic [16:0] CAL_FULL_CYC = acs_pkg::CAL_FULL_DEF,
  parameter logic [16:0] CAL_DAC_FS_CYC = acs_pkg::CAL_DAC_FS_DEF,
  parameter logic [16:0] CAL_OFFSET_CYC = acs_pkg::CAL_OFFSET_DEF
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic sample_start_n,
  input wire logic cal_start,
  input wire logic [2:0] iface_mode,
  input wire logic edge_select,
  input wire logic [11:0] sample_in,
  input wire logic frame_sync_n,
  input wire logic serial_clk_in,
  input wire logic serial_din_in,
  output logic serial_din_out,
  output logic serial_din_oe,
  output logic serial_dout,
  output logic serial_dout_oe,
  output logic serial_clk_out,
  output logic serial_clk_oe,
  output logic busy
);

  // master clock domain synchronisers
  logic [7:0] sync_a;
  logic [7:0] sync_b;
  logic [7:0] sync_c;
  logic rx_tog;
  logic tx_ack;
  wire [7:0] async_in = {tx_ack, rx_tog, iface_mode, frame_sync_n, cal_start, sample_start_n};

  genvar gi;
  for (gi = 0; gi < acs_pkg::NSYNC; gi++) begin : g_sync
    always_ff @(posedge clk) begin
      if (srst) begin
        sync_a[gi] <= acs_pkg::SYNC_RST[gi];
        sync_b[gi] <= acs_pkg::SYNC_RST[gi];
        sync_c[gi] <= acs_pkg::SYNC_RST[gi];
      end else begin
        sync_a[gi] <= async_in[gi];
        sync_b[gi] <= sync_a[gi];
        sync_c[gi] <= sync_b[gi];
      end
    end
  end

  wire start_fall = sync_c[acs_pkg::SY_START] & ~sync_b[acs_pkg::SY_START];
  wire cal_rise = ~sync_c[acs_pkg::SY_CAL] & sync_b[acs_pkg::SY_CAL];
  wire rx_new = sync_c[acs_pkg::SY_RX] ^ sync_b[acs_pkg::SY_RX];
  wire tx_ack_s = sync_b[acs_pkg::SY_ACK];
  wire frame_s = ~sync_b[acs_pkg::SY_FRAME];
  wire [2:0] mode_s = sync_b[acs_pkg::SY_MODE_HI:acs_pkg::SY_MODE_LO];

  // command word from the link; stable for two cycles before its toggle lands
  logic [15:0] rx_word;
  wire [1:0] cmd_cal = rx_word[acs_pkg::CMD_CAL_HI:acs_pkg::CMD_CAL_LO];
  wire sw_conv = rx_new & rx_word[acs_pkg::CMD_CONV_BIT];
  wire sw_cal = rx_new & (cmd_cal != 2'h0);

  // job sequencer
  acs_pkg::acs_state_t state;
  acs_pkg::acs_state_t next_state;
  logic [16:0] count;
  logic [16:0] next_count;
  acs_pkg::acs_job_t job;
  acs_pkg::acs_job_t next_job;
  logic [11:0] sample_hold;
  logic buf_in_ready;

  wire [16:0] cal_len_sw = (cmd_cal == 2'h1) ? CAL_FULL_CYC :
                           (cmd_cal == 2'h2) ? CAL_DAC_FS_CYC : CAL_OFFSET_CYC;
  wire conv_last = (state == acs_pkg::ST_CONV) && (count == 17'h00000);
  wire push_valid = conv_last || (state == acs_pkg::ST_PUSH);
  wire job_start = (state == acs_pkg::ST_IDLE) && (next_state != acs_pkg::ST_IDLE);

  always_comb begin
    next_state = state;
    next_count = count;
    next_job = job;
    case (state)
      acs_pkg::ST_IDLE: begin
        if (start_fall || sw_conv) begin
          next_state = acs_pkg::ST_CONV;
          next_count = acs_pkg::CONV_CYC - 17'h00001;
          next_job = acs_pkg::JOB_NONE;
        end else if (cal_rise) begin
          next_state = acs_pkg::ST_CAL;
          next_count = CAL_FULL_CYC - 17'h00001;
          next_job = acs_pkg::JOB_CAL_FULL;
        end else if (sw_cal) begin
          next_state = acs_pkg::ST_CAL;
          next_count = cal_len_sw - 17'h00001;
          next_job = acs_pkg::acs_job_t'(cmd_cal);
        end
      end
      acs_pkg::ST_CONV: begin
        if (count != 17'h00000) begin
          next_count = count - 17'h00001;
        end else if (buf_in_ready) begin
          next_state = acs_pkg::ST_IDLE;
        end else begin
          // result buffer full: hold busy rather than drop a word
          next_state = acs_pkg::ST_PUSH;
        end
      end
      acs_pkg::ST_PUSH: begin
        if (buf_in_ready) begin
          next_state = acs_pkg::ST_IDLE;
        end
      end
      acs_pkg::ST_CAL: begin
        if (count != 17'h00000) begin
          next_count = count - 17'h00001;
        end else begin
          next_state = acs_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = acs_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= acs_pkg::ST_IDLE;
      count <= 17'h00000;
      job <= acs_pkg::JOB_NONE;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      job <= next_job;
      busy <= (next_state != acs_pkg::ST_IDLE);
    end
  end

  // track and hold: value taken at the conversion start
  always_ff @(posedge clk) begin
    if (srst) begin
      sample_hold <= 12'h000;
    end else if (job_start && next_state == acs_pkg::ST_CONV) begin
      sample_hold <= sample_in;
    end
  end

  // result buffer and hand-off to the link
  logic buf_out_valid;
  logic [15:0] buf_out_data;
  logic tx_req;
  logic [15:0] tx_hold;
  wire tx_idle = (tx_req == tx_ack_s);
  // hand-off only between frames: the link clock may stop outside frames
  wire tx_take = tx_idle & ~frame_s;

  acs_buf2 #(
    .WIDTH(acs_pkg::WORD_W),
    .DEPTH(2)
  ) u_buf (
    .clk(clk),
    .srst(srst),
    .in_valid(push_valid),
    .in_ready(buf_in_ready),
    .in_data({4'h0, sample_hold}),
    .out_valid(buf_out_valid),
    .out_ready(tx_take),
    .out_data(buf_out_data)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_req <= 1'b0;
      tx_hold <= 16'h0000;
    end else if (buf_out_valid && tx_take) begin
      tx_hold <= buf_out_data;
      tx_req <= ~tx_req;
    end
  end

  // generated serial clock; idles high so the first edge of a frame falls
  wire gen_mode = (mode_s == acs_pkg::MODE_GEN_A) || (mode_s == acs_pkg::MODE_GEN_B);

  always_ff @(posedge clk) begin
    if (srst) begin
      serial_clk_out <= 1'b1;
      serial_clk_oe <= 1'b0;
    end else begin
      serial_clk_oe <= gen_mode;
      serial_clk_out <= (gen_mode && frame_s) ? ~serial_clk_out : 1'b1;
    end
  end

  // link domain; edge_select low inverts the clock, so every edge swaps
  wire link_clk = serial_clk_in ^ ~edge_select;
  logic [1:0] lrst_sync;
  logic [2:0] lmode_a;
  logic [2:0] lmode_b;
  wire link_rst = lrst_sync[1];
  wire shared = (lmode_b == acs_pkg::MODE_SHARED);

  // needs link clock edges while srst is held
  always_ff @(posedge link_clk) begin
    lrst_sync <= {lrst_sync[0], srst};
    lmode_a <= iface_mode;
    lmode_b <= lmode_a;
  end

  // receive half: sample on rising edges; frame sync high clears the frame
  logic [5:0] rcnt;
  logic [15:0] rx_sh;
  logic din_oe;

  always_ff @(posedge link_clk or posedge frame_sync_n) begin
    if (frame_sync_n) begin
      rcnt <= 6'h00;
      rx_sh <= 16'h0000;
      din_oe <= 1'b0;
    end else begin
      if (rcnt != acs_pkg::CNT_SAT) begin
        rcnt <= rcnt + 6'h01;
      end
      rx_sh <= {rx_sh[14:0], serial_din_in};
      if (shared && rcnt == acs_pkg::RX_LAST) begin
        din_oe <= 1'b1;
      end else if (rcnt == acs_pkg::TX_LAST_SHARED) begin
        din_oe <= 1'b0;
      end
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      rx_tog <= 1'b0;
      rx_word <= 16'h0000;
    end else if (rcnt == acs_pkg::RX_LAST) begin
      rx_word <= {rx_sh[14:0], serial_din_in};
      rx_tog <= ~rx_tog;
    end
  end

  // transmit half: new bit after each falling edge
  logic [5:0] fcnt;
  logic [15:0] tx_sh;
  logic tx_bit;
  logic dout_oe;
  // tx_req can still move on the first two master clock edges after frame sync falls, then holds, so it is static within a frame
  wire tx_pend_l = (tx_req != tx_ack);
  wire [5:0] tx_base = shared ? acs_pkg::TX_BASE_SHARED : 6'h00;
  wire tx_load = (fcnt == tx_base);
  // no pending word sends zeros; tx_hold is frozen while the toggle differs
  wire [15:0] tx_src = tx_pend_l ? tx_hold : 16'h0000;

  always_ff @(negedge link_clk) begin
    if (link_rst) begin
      tx_ack <= 1'b0;
    end else if (tx_load && tx_pend_l) begin
      tx_ack <= ~tx_ack;
    end
  end

  always_ff @(negedge link_clk or posedge frame_sync_n) begin
    if (frame_sync_n) begin
      fcnt <= 6'h00;
      tx_sh <= 16'h0000;
      tx_bit <= 1'b0;
      dout_oe <= 1'b0;
    end else begin
      if (fcnt != acs_pkg::CNT_SAT) begin
        fcnt <= fcnt + 6'h01;
      end
      dout_oe <= ~shared;
      if (tx_load) begin
        tx_bit <= tx_src[15];
        tx_sh <= {tx_src[14:0], 1'b0};
      end else begin
        tx_bit <= tx_sh[15];
        tx_sh <= {tx_sh[14:0], 1'b0};
      end
    end
  end

  assign serial_dout = tx_bit;
  assign serial_din_out = tx_bit;
  assign serial_dout_oe = dout_oe;
  assign serial_din_oe = din_oe;

  // checking helpers
  localparam int CONV_N = 18;
  logic [16:0] busy_len;
  logic stall_seen;
  acs_pkg::acs_job_t last_job;
  logic last_conv;

  always_ff @(posedge clk) begin
    if (srst) begin
      busy_len <= 17'h00000;
      stall_seen <= 1'b0;
      last_job <= acs_pkg::JOB_NONE;
      last_conv <= 1'b0;
    end else begin
      busy_len <= busy ? busy_len + 17'h00001 : 17'h00000;
      if (job_start) begin
        stall_seen <= 1'b0;
        last_job <= next_job;
        last_conv <= (next_state == acs_pkg::ST_CONV);
      end else if (state == acs_pkg::ST_PUSH) begin
        stall_seen <= 1'b1;
      end
    end
  end

  sequence seq_start_seen;
    (start_fall || sw_conv) && state == acs_pkg::ST_IDLE;
  endsequence

  sequence seq_cal_seen;
    cal_rise && !start_fall && !sw_conv && state == acs_pkg::ST_IDLE;
  endsequence

  AST_START_BUSY: assert property (@(posedge clk) disable iff (srst)
    seq_start_seen |=> busy [*8])
    else $error("busy did not follow a conversion start");

  AST_CONV_LEN: assert property (@(posedge clk) disable iff (srst)
    $fell(busy) && last_conv && !stall_seen |-> busy_len == 17'(CONV_N))
    else $error("conversion busy length is not eighteen");

  AST_BUSY_HOLD: assert property (@(posedge clk) disable iff (srst)
    busy && state != acs_pkg::ST_IDLE |-> busy == (state != acs_pkg::ST_IDLE) ##1
    (busy || $past(next_state) == acs_pkg::ST_IDLE))
    else $error("busy dropped while a job was running");

  AST_CAL_FULL_LEN: assert property (@(posedge clk) disable iff (srst)
    $fell(busy) && !last_conv && last_job == acs_pkg::JOB_CAL_FULL |-> busy_len == CAL_FULL_CYC)
    else $error("full calibration length wrong");

  AST_CAL_DAC_LEN: assert property (@(posedge clk) disable iff (srst)
    $fell(busy) && !last_conv && last_job == acs_pkg::JOB_CAL_DAC_FS |->
    busy_len == CAL_DAC_FS_CYC)
    else $error("dac and full-scale calibration length wrong");

  AST_CAL_OFS_LEN: assert property (@(posedge clk) disable iff (srst)
    $fell(busy) && !last_conv && last_job == acs_pkg::JOB_CAL_OFFSET |->
    busy_len == CAL_OFFSET_CYC)
    else $error("offset calibration length wrong");

  AST_CAL_BUSY: assert property (@(posedge clk) disable iff (srst)
    seq_cal_seen |=> busy && state == acs_pkg::ST_CAL)
    else $error("busy late after calibrate edge");

  AST_SW_START: assert property (@(posedge clk) disable iff (srst)
    sw_conv && state == acs_pkg::ST_IDLE |=> state == acs_pkg::ST_CONV && count == 17'h00011)
    else $error("command word did not start a conversion");

  AST_GEN_CLK: assert property (@(posedge clk) disable iff (srst)
    gen_mode && frame_s && $past(gen_mode && frame_s) |=> serial_clk_out != $past(serial_clk_out))
    else $error("generated serial clock not toggling");

  AST_DOUT_Z: assert property (@(posedge link_clk) disable iff (link_rst)
    shared |-> !dout_oe)
    else $error("data output driven in shared-pin mode");

  AST_DIN_TURN: assert property (@(posedge link_clk) disable iff (link_rst)
    $rose(din_oe) |-> shared && $past(rcnt) == acs_pkg::RX_LAST)
    else $error("shared pin turned at the wrong edge");

endmodule

/* hw/acs_pkg.sv */
/*
  Shared constants of the conversion and calibration sequencer: job lengths,
  state codes, interface modes and serial framing.
  Assumes one master clock of 10 ns; job lengths are counted in its periods, serial framing in link clock edges.
*/
package acs_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int CNT_W = 17;

  // job lengths in master clock periods
  localparam logic [16:0] CONV_CYC = 17'h00012;
  localparam logic [16:0] CAL_FULL_DEF = 17'h1e855;
  localparam logic [16:0] CAL_DAC_FS_DEF = 17'h1b20a;
  localparam logic [16:0] CAL_OFFSET_DEF = 17'h0364b;

  // job states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_CONV = 4'h2,
    ST_PUSH = 4'h4,
    ST_CAL = 4'h8
  } acs_state_t;

  typedef enum logic [1:0] {
    JOB_NONE = 2'h0,
    JOB_CAL_FULL = 2'h1,
    JOB_CAL_DAC_FS = 2'h2,
    JOB_CAL_OFFSET = 2'h3
  } acs_job_t;

  // interface modes on the mode strap
  localparam logic [2:0] MODE_SHARED = 3'h2;
  localparam logic [2:0] MODE_GEN_A = 3'h4;
  localparam logic [2:0] MODE_GEN_B = 3'h5;

  // command word received on the serial input
  localparam int CMD_CONV_BIT = 15;
  localparam int CMD_CAL_HI = 14;
  localparam int CMD_CAL_LO = 13;

  // serial framing
  localparam int WORD_W = 16;
  localparam logic [5:0] RX_LAST = 6'h0f;
  localparam logic [5:0] TX_BASE_SHARED = 6'h10;
  localparam logic [5:0] TX_LAST_SHARED = 6'h1f;
  localparam logic [5:0] CNT_SAT = 6'h3f;

  // master-domain synchroniser lanes and their idle values
  localparam int NSYNC = 8;
  localparam logic [7:0] SYNC_RST = 8'h05;
  localparam int SY_START = 0;
  localparam int SY_CAL = 1;
  localparam int SY_FRAME = 2;
  localparam int SY_MODE_LO = 3;
  localparam int SY_MODE_HI = 5;
  localparam int SY_RX = 6;
  localparam int SY_ACK = 7;

endpackage

/* hw/acs_buf2.sv */
/*
  Two-entry result buffer with valid/ready on both sides.
  Assumes both sides on the master clock; full and empty are exact.
*/
`timescale 1ns/10ps
module acs_buf2 #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] DEPTH_C = DEPTH[PW:0];

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] fill;

  wire do_push = in_valid & in_ready;
  wire do_pop = out_valid & out_ready;
  wire [PW-1:0] wr_inc = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
  wire [PW-1:0] rd_inc = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);

  assign in_ready = (fill != DEPTH_C);
  assign out_valid = (fill != '0);
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_inc;
      end
      if (do_pop) begin
        rd_ptr <= rd_inc;
      end
      fill <= fill + (PW+1)'(do_push) - (PW+1)'(do_pop);
    end
  end

endmodule

/* tb/acs_host_model.sv */
/*
  Host-side serial port model for the sequencer: frame sync, serial clock and
  serial data. Assumes the bench calls frame() with the link idle; in the
  generated-clock modes the device clock is looped back here.
*/
`timescale 1ns/10ps
module acs_host_model (
  input wire logic srst,
  input wire logic pol,
  input wire logic gen,
  input wire logic serial_clk_out,
  input wire logic serial_din_out,
  input wire logic serial_din_oe,
  input wire logic serial_dout,
  input wire logic serial_dout_oe,
  output logic frame_sync_n,
  output logic serial_clk_in,
  output logic serial_din_in
);
  logic sclk_host;
  logic run;
  logic din_host;
  logic sclk_v;
  int post;

  initial begin
    post = 0;
    frame_sync_n = 1'b1;
    sclk_host = 1'b1;
    run = 1'b0;
    din_host = 1'b0;
  end

  // 48 ns link clock; stands at its idle level between frames
  initial begin
    #7;
    forever begin
      #24;
      if (srst) begin
        post = 6;
      end
      if (run || srst || post > 0) begin
        sclk_host = ~sclk_host;
        if (!srst && !run && post > 0) begin
          post--;
        end
      end else begin
        sclk_host = pol;
      end
    end
  end

  // link reset is synced on the link clock: clock it through reset and a short tail
  assign serial_clk_in = (gen && !srst && post == 0) ? serial_clk_out : sclk_host;
  assign sclk_v = serial_clk_in ~^ pol;
  assign serial_din_in = serial_din_oe ? serial_din_out : din_host;

  task automatic frame(input logic [15:0] cmd, input logic sh, output logic [15:0] rx,
                       output logic oe_all);
    int nb;
    nb = sh ? 32 : 16;
    oe_all = 1'b1;
    rx = 16'h0000;
    frame_sync_n = 1'b0;
    // generated clock starts on its own a few cycles after sync falls
    if (!gen) begin
      #30;
    end
    run = 1'b1;
    for (int j = 0; j < nb; j++) begin
      @(negedge sclk_v);
      #2 din_host = (j < 16) ? cmd[15 - j] : 1'b0;
      @(posedge sclk_v);
      if (!sh) begin
        rx[15 - j] = serial_dout;
        oe_all = oe_all & serial_dout_oe;
      end else if (j >= 16) begin
        rx[31 - j] = serial_din_in;
        oe_all = oe_all & serial_din_oe;
      end
    end
    // stop on the active edge so no extra edge appears
    run = 1'b0;
    #1 frame_sync_n = 1'b1;
    din_host = ~din_host;
  endtask
endmodule

/* tb/tb_adc_conversion_calibration_sequencer.sv */
/*
  Self-checking bench of the conversion and calibration sequencer.
  Assumes the host model drives the serial link and shortened cal lengths.
*/
`timescale 1ns/10ps
module tb_adc_conversion_calibration_sequencer;
  localparam logic [16:0] FULL = 17'h00028;
  localparam logic [16:0] DACFS = 17'h0001e;
  localparam logic [16:0] OFFS = 17'h00014;
  logic clk = 1'b0;
  logic srst;
  logic sample_start_n;
  logic cal_start;
  logic [2:0] iface_mode;
  logic edge_select;
  logic [11:0] sample_in;
  logic frame_sync_n;
  logic serial_clk_in;
  logic serial_din_in;
  logic serial_din_out;
  logic serial_din_oe;
  logic serial_dout;
  logic serial_dout_oe;
  logic serial_clk_out;
  logic serial_clk_oe;
  logic busy;
  logic gen;
  int mismatches;
  int n_tests;
  int cyc;

  assign gen = (iface_mode == acs_pkg::MODE_GEN_A) || (iface_mode == acs_pkg::MODE_GEN_B);

  acs_sequencer #(.CAL_FULL_CYC(FULL), .CAL_DAC_FS_CYC(DACFS), .CAL_OFFSET_CYC(OFFS)) dut_u (
    .clk(clk), .srst(srst), .sample_start_n(sample_start_n), .cal_start(cal_start),
    .iface_mode(iface_mode), .edge_select(edge_select), .sample_in(sample_in),
    .frame_sync_n(frame_sync_n), .serial_clk_in(serial_clk_in),
    .serial_din_in(serial_din_in), .serial_din_out(serial_din_out),
    .serial_din_oe(serial_din_oe), .serial_dout(serial_dout),
    .serial_dout_oe(serial_dout_oe), .serial_clk_out(serial_clk_out),
    .serial_clk_oe(serial_clk_oe), .busy(busy));

  acs_host_model host_u (
    .srst(srst), .pol(edge_select), .gen(gen), .serial_clk_out(serial_clk_out),
    .serial_din_out(serial_din_out), .serial_din_oe(serial_din_oe),
    .serial_dout(serial_dout), .serial_dout_oe(serial_dout_oe),
    .frame_sync_n(frame_sync_n), .serial_clk_in(serial_clk_in),
    .serial_din_in(serial_din_in));

  always #5 clk = ~clk;

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic do_reset(input logic [2:0] m, input logic e);
    @(negedge clk);
    iface_mode = m;
    edge_select = e;
    srst = 1'b1;
    repeat (30) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
    chk({31'h0, busy}, 32'h0);
    chk({31'h0, serial_clk_oe}, {31'h0, gen});
  endtask

  // cycles to busy rise, then cycles busy stays high
  task automatic job_len(output int rise, output int n);
    rise = 0;
    n = 0;
    while (busy !== 1'b1 && rise < 200) begin
      @(negedge clk);
      rise++;
    end
    while (busy === 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic pulse_start(input logic [11:0] v);
    repeat (40) @(negedge clk);
    sample_in = v;
    sample_start_n = 1'b0;
  endtask

  task automatic read_frame(input logic [15:0] cmd, input logic [15:0] exp);
    logic [15:0] rx;
    logic oe;
    chk({31'h0, serial_dout_oe}, 32'h0);
    host_u.frame(cmd, iface_mode == acs_pkg::MODE_SHARED, rx, oe);
    chk({16'h0, rx}, {16'h0, exp});
    chk({31'h0, oe}, 32'h1);
    #20 chk({31'h0, serial_dout_oe}, 32'h0);
    chk({31'h0, serial_din_oe}, 32'h0);
    @(negedge clk);
  endtask

  task automatic sc_pin_conv(input logic [11:0] v);
    int r;
    int n;
    pulse_start(v);
    job_len(r, n);
    sample_start_n = 1'b1;
    chk(32'(r), 32'h3);
    chk(32'(n), 32'(acs_pkg::CONV_CYC));
    read_frame(16'h0000, {4'h0, v});
  endtask

  task automatic sc_cal_pin();
    int r;
    int n;
    repeat (40) @(negedge clk);
    cal_start = 1'b1;
    job_len(r, n);
    cal_start = 1'b0;
    chk(32'(r), 32'h3);
    chk(32'(n), 32'(FULL));
  endtask

  // command word jobs; result readout rides on the next frame
  task automatic sc_cmd_jobs();
    logic [15:0] cmds [4] = '{16'h8000, 16'h2000, 16'h4000, 16'h6000};
    int lens [4] = '{int'(acs_pkg::CONV_CYC), int'(FULL), int'(DACFS), int'(OFFS)};
    int r;
    int n;
    sample_in = 12'h9c4;
    for (int k = 0; k < 4; k++) begin
      fork
        read_frame(cmds[k], (k == 1) ? 16'h09c4 : 16'h0000);
        job_len(r, n);
      join
      chk(32'(n), 32'(lens[k]));
    end
  endtask

  // fill the result buffer until it stalls the job, then drain it
  task automatic sc_buffer();
    int r;
    int n;
    for (int k = 1; k <= 3; k++) begin
      pulse_start(12'(k * 12'h111));
      job_len(r, n);
      sample_start_n = 1'b1;
      chk(32'(n), 32'(acs_pkg::CONV_CYC));
    end
    pulse_start(12'h444);
    repeat (30) @(negedge clk);
    sample_start_n = 1'b1;
    chk({31'h0, busy}, 32'h1);
    read_frame(16'h0000, 16'h0111);
    repeat (10) @(negedge clk);
    chk({31'h0, busy}, 32'h0);
    read_frame(16'h0000, 16'h0222);
    read_frame(16'h0000, 16'h0333);
    read_frame(16'h0000, 16'h0444);
    read_frame(16'h0000, 16'h0000);
  endtask

  initial begin
    srst = 1'b1;
    sample_start_n = 1'b1;
    cal_start = 1'b0;
    iface_mode = 3'h1;
    edge_select = 1'b1;
    sample_in = 12'h000;
    mismatches = 0;
    n_tests = 0;
    cyc = 0;
    do_reset(3'h1, 1'b1);
    sc_pin_conv(12'h5a3);
    sc_cal_pin();
    sc_cmd_jobs();
    sc_buffer();
    do_reset(3'h1, 1'b0);
    sc_pin_conv(12'ha5c);
    do_reset(acs_pkg::MODE_SHARED, 1'b1);
    sc_pin_conv(12'h6b2);
    do_reset(acs_pkg::MODE_GEN_A, 1'b1);
    sc_pin_conv(12'h3e7);
    do_reset(acs_pkg::MODE_GEN_B, 1'b1);
    sc_pin_conv(12'h0f1);
    give_verdict();
  end
endmodule
